/* File: shared/sp_consts.svh */
/*
 Offsets, field positions, reset values and timing counts of the serial port.
 Assumes it is included by bare name by the design and bench files.
*/
`ifndef SP_CONSTS_SVH
`define SP_CONSTS_SVH

// -------------------------------------------------
// Register offsets
// -------------------------------------------------
`define SP_OFS_MODE 8'h00
`define SP_OFS_TXBUF 8'h04
`define SP_OFS_RXBUF 8'h08
`define SP_OFS_STAT 8'h0c
`define SP_OFS_CTRL 8'h10
`define SP_OFS_RATE 8'h14

// -------------------------------------------------
// Reset values
// -------------------------------------------------
`define SP_RST_MODE 8'h00
`define SP_RST_TXBUF 8'hff
`define SP_RST_RXBUF 8'h00
`define SP_RST_RATE 8'h00

// -------------------------------------------------
// Field positions
// -------------------------------------------------
`define SP_ST_TXE 7
`define SP_ST_RXF 6
`define SP_ST_OVR 5
`define SP_ST_FER 4
`define SP_ST_PER 3
`define SP_ST_MPB 1
`define SP_CT_TXEN 5
`define SP_CT_RXEN 4
`define SP_CT_MPBT 0

// -------------------------------------------------
// Timing
// -------------------------------------------------
`define SP_OVERSAMPLE 16
`endif

/* File: shared/sp_pkg.sv */
/*
 Types of the serial port: frame mode layout and receiver states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package sp_pkg;
    typedef struct packed {
        logic commSync;
        logic charLen;
        logic parityOn;
        logic oddParity;
        logic stopTwo;
        logic multiprocFormatSel;
        logic [1:0] baudPrescaleSel;
    } sp_mode_s;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_EXTRA = 3'b011,
        RX_STOP = 3'b100
    } sp_rx_state_e;
endpackage

/* File: rtl/sp_serial_port.sv */
/*
 Serial port data path and frame format, behind an AHB-Lite slave.
 Assumes a single AHB-Lite master, ref_clk at 20 MHz, pins synchronous to it.
*/
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "sp_consts.svh"
module sp_serial_port #(
    parameter int OVS = `SP_OVERSAMPLE
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic standby,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rxd,
    output logic txd,
    output logic serClk
);
    // -------------------------------------------------
    // Parameter check
    // -------------------------------------------------
    if (OVS < 4 || OVS > 16)
    begin : g_bad_ovs
        $error("OVS must lie between 4 and 16");
    end

    localparam logic [3:0] PH_LAST = 4'(OVS - 1);
    localparam logic [3:0] PH_MID = 4'(OVS / 2 - 1);
    localparam logic [3:0] PH_HALF = 4'(OVS / 2);

    // -------------------------------------------------
    // Functions
    // -------------------------------------------------
    function automatic logic [5:0] preLimit(input logic [1:0] sel);
        unique case (sel)
            2'b00: preLimit = 6'h00;
            2'b01: preLimit = 6'h03;
            2'b10: preLimit = 6'h0f;
            2'b11: preLimit = 6'h3f;
        endcase
    endfunction

    // Frame image, LSB leaves first; unused upper bits stay at idle level
    function automatic logic [15:0] buildFrame(input sp_pkg::sp_mode_s m,
                                               input logic [7:0] d,
                                               input logic mpb);
        logic [11:0] f;
        logic [3:0] n;
        logic [3:0] len;
        logic x;
        logic ext;
        f = 12'hfff;
        len = m.charLen ? 4'h7 : 4'h8;
        ext = m.multiprocFormatSel | m.parityOn;
        x = m.multiprocFormatSel ? mpb : (^(d & {~m.charLen, 7'h7f})) ^ m.oddParity;
        if (m.commSync)
        begin
            f = {4'hf, d};
            n = 4'h8;
        end
        else
        begin
            f[0] = 1'b0;
            for (int i = 0; i < 8; i++)
            begin
                if (4'(i) < len)
                    f[i + 1] = d[i];
            end
            if (ext)
                f[len + 4'h1] = x;
            n = 4'h2 + len + {3'h0, ext} + {3'h0, m.stopTwo};
        end
        buildFrame = {n, f};
    endfunction

    // -------------------------------------------------
    // Registers and state
    // -------------------------------------------------
    sp_pkg::sp_mode_s mode;
    sp_pkg::sp_rx_state_e rxState;
    logic [7:0] txBuf, rxBuf, rate;
    logic txEmpty, rxFull, overrun, frameErr, parityErr, rxMpb;
    logic txEn, rxEn, txMpb;
    logic apValid, apWrite, rdWait;
    logic [7:0] apAddr;
    logic [5:0] preCnt;
    logic [7:0] rateCnt;
    logic osTick;
    logic [11:0] txShift;
    logic [3:0] txLeft, txPhase;
    logic [3:0] rxPhase, rxIdx;
    logic [7:0] rxShift, rxWord;
    logic rxPar, rxDone, rxStopBad, rxParBad, rxMpbIn;

    wire isSync = mode.commSync;
    wire sevenBit = !isSync && mode.charLen;
    wire useMp = !isSync && mode.multiprocFormatSel;
    wire usePar = !isSync && mode.parityOn && !mode.multiprocFormatSel;
    wire [3:0] dataLen = sevenBit ? 4'h7 : 4'h8;
    wire txBusy = txLeft != 4'h0;
    wire txLoad = !txBusy && txEn && !txEmpty;
    wire txBitEnd = osTick && txBusy && txPhase == PH_LAST;
    wire sp_pkg::sp_mode_s effMode = '{commSync: isSync, charLen: sevenBit,
        parityOn: usePar, oddParity: mode.oddParity, stopTwo: mode.stopTwo & ~isSync,
        multiprocFormatSel: useMp, baudPrescaleSel: mode.baudPrescaleSel};

    // -------------------------------------------------
    // AHB-Lite slave
    // -------------------------------------------------
    wire take = hsel && htrans[1] && hready;
    wire wrStb = apValid && apWrite;
    wire rdStb = apValid && !apWrite;
    wire wrStat = wrStb && apAddr == `SP_OFS_STAT;

    // Reads take one wait state so the answer comes from a flop
    assign hreadyout = !(rdStb && !rdWait);
    assign hresp = 1'b0;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            apValid <= 1'b0;
            apWrite <= 1'b0;
            apAddr <= 8'h00;
        end
        else if (hready)
        begin
            apValid <= take;
            if (take)
            begin
                apAddr <= {haddr[7:2], 2'b00};
                apWrite <= hwrite;
            end
        end
    end

    // Shifters are never decoded, so software cannot reach them
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdWait <= 1'b0;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            rdWait <= rdStb && !rdWait;
            if (rdStb && !rdWait)
            begin
                unique case (apAddr)
                    `SP_OFS_MODE: hrdata <= {24'h0, mode};
                    `SP_OFS_TXBUF: hrdata <= {24'h0, txBuf};
                    `SP_OFS_RXBUF: hrdata <= {24'h0, rxBuf};
                    `SP_OFS_STAT: hrdata <= {24'h0, txEmpty, rxFull, overrun,
                                             frameErr, parityErr, 1'b0, rxMpb, 1'b0};
                    `SP_OFS_CTRL: hrdata <= {24'h0, 2'b00, txEn, rxEn, 3'b000, txMpb};
                    `SP_OFS_RATE: hrdata <= {24'h0, rate};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // -------------------------------------------------
    // Software registers
    // -------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode <= `SP_RST_MODE;
            txBuf <= `SP_RST_TXBUF;
            rate <= `SP_RST_RATE;
            txEn <= 1'b0;
            rxEn <= 1'b0;
            txMpb <= 1'b0;
        end
        else if (standby)
        begin
            mode <= `SP_RST_MODE;
            txBuf <= `SP_RST_TXBUF;
            rate <= `SP_RST_RATE;
            txEn <= 1'b0;
            rxEn <= 1'b0;
            txMpb <= 1'b0;
        end
        else if (wrStb)
        begin
            if (apAddr == `SP_OFS_MODE)
                mode <= hwdata[7:0];
            if (apAddr == `SP_OFS_TXBUF)
                txBuf <= hwdata[7:0];
            if (apAddr == `SP_OFS_RATE)
                rate <= hwdata[7:0];
            if (apAddr == `SP_OFS_CTRL)
            begin
                txEn <= hwdata[`SP_CT_TXEN];
                rxEn <= hwdata[`SP_CT_RXEN];
                txMpb <= hwdata[`SP_CT_MPBT];
            end
        end
    end

    // -------------------------------------------------
    // Flags: hardware set wins over a software clear
    // -------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            txEmpty <= 1'b1;
        else if (standby || !txEn || txLoad)
            txEmpty <= 1'b1;
        else if (wrStat && !hwdata[`SP_ST_TXE])
            txEmpty <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rxBuf <= `SP_RST_RXBUF;
            rxFull <= 1'b0;
            overrun <= 1'b0;
            frameErr <= 1'b0;
            parityErr <= 1'b0;
            rxMpb <= 1'b0;
        end
        else if (standby)
        begin
            rxBuf <= `SP_RST_RXBUF;
            rxFull <= 1'b0;
            overrun <= 1'b0;
            frameErr <= 1'b0;
            parityErr <= 1'b0;
            rxMpb <= 1'b0;
        end
        else
        begin
            if (wrStat && !hwdata[`SP_ST_RXF])
                rxFull <= 1'b0;
            if (wrStat && !hwdata[`SP_ST_OVR])
                overrun <= 1'b0;
            if (wrStat && !hwdata[`SP_ST_FER])
                frameErr <= 1'b0;
            if (wrStat && !hwdata[`SP_ST_PER])
                parityErr <= 1'b0;
            // Unread data is kept; the new character is lost as overrun
            if (rxDone && rxFull)
                overrun <= 1'b1;
            else if (rxDone)
            begin
                rxBuf <= rxWord;
                rxFull <= 1'b1;
                rxMpb <= rxMpbIn;
                if (rxStopBad)
                    frameErr <= 1'b1;
                if (rxParBad)
                    parityErr <= 1'b1;
            end
        end
    end

    // -------------------------------------------------
    // Prescaler and bit-rate divider
    // -------------------------------------------------
    wire preTick = preCnt >= preLimit(mode.baudPrescaleSel);

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            preCnt <= 6'h00;
            rateCnt <= 8'h00;
            osTick <= 1'b0;
        end
        else
        begin
            preCnt <= preTick ? 6'h00 : preCnt + 6'h01;
            osTick <= preTick && rateCnt >= rate;
            if (preTick)
                rateCnt <= (rateCnt >= rate) ? 8'h00 : rateCnt + 8'h01;
        end
    end

    // -------------------------------------------------
    // Transmitter
    // -------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            txShift <= 12'hfff;
            txLeft <= 4'h0;
            txPhase <= 4'h0;
        end
        else if (standby)
        begin
            txShift <= 12'hfff;
            txLeft <= 4'h0;
            txPhase <= 4'h0;
        end
        else if (txLoad)
        begin
            {txLeft, txShift} <= buildFrame(effMode, txBuf, txMpb);
            txPhase <= 4'h0;
        end
        else if (osTick && txBusy)
        begin
            txPhase <= (txPhase == PH_LAST) ? 4'h0 : txPhase + 4'h1;
            if (txPhase == PH_LAST)
            begin
                txShift <= {1'b1, txShift[11:1]};
                txLeft <= txLeft - 4'h1;
            end
        end
    end

    assign txd = txShift[0];

    // Clock is low in the first half of each synchronous bit
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            serClk <= 1'b1;
        else
            serClk <= !(isSync && txBusy && txPhase < PH_HALF);
    end

    // -------------------------------------------------
    // Receiver
    // -------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rxState <= sp_pkg::RX_IDLE;
            rxPhase <= 4'h0;
            rxIdx <= 4'h0;
            rxShift <= 8'h00;
            rxPar <= 1'b0;
            rxDone <= 1'b0;
            rxWord <= 8'h00;
            rxStopBad <= 1'b0;
            rxParBad <= 1'b0;
            rxMpbIn <= 1'b0;
        end
        else if (standby)
        begin
            rxState <= sp_pkg::RX_IDLE;
            rxPhase <= 4'h0;
            rxIdx <= 4'h0;
            rxDone <= 1'b0;
        end
        else
        begin
            rxDone <= 1'b0;
            // Synchronous receive samples at the end of each bit, while the clock is still high
            if (isSync && rxState == sp_pkg::RX_IDLE)
            begin
                if (rxEn && txBitEnd)
                begin
                    rxShift <= {rxd, rxShift[7:1]};
                    rxIdx <= (rxIdx == 4'h7) ? 4'h0 : rxIdx + 4'h1;
                    if (rxIdx == 4'h7)
                    begin
                        rxDone <= 1'b1;
                        rxWord <= {rxd, rxShift[7:1]};
                        rxStopBad <= 1'b0;
                        rxParBad <= 1'b0;
                        rxMpbIn <= 1'b0;
                    end
                end
            end
            else if (osTick)
            begin
                unique case (rxState)
                    sp_pkg::RX_IDLE:
                        if (rxEn && !rxd)
                        begin
                            rxState <= sp_pkg::RX_START;
                            rxPhase <= 4'h0;
                        end
                    sp_pkg::RX_START:
                        if (rxPhase == PH_MID)
                        begin
                            rxState <= rxd ? sp_pkg::RX_IDLE : sp_pkg::RX_DATA;
                            rxPhase <= 4'h0;
                            rxIdx <= 4'h0;
                        end
                        else
                            rxPhase <= rxPhase + 4'h1;
                    sp_pkg::RX_DATA:
                        if (rxPhase == PH_LAST)
                        begin
                            rxPhase <= 4'h0;
                            rxShift <= {rxd, rxShift[7:1]};
                            rxIdx <= rxIdx + 4'h1;
                            if (rxIdx == dataLen - 4'h1)
                                rxState <= (usePar || useMp) ? sp_pkg::RX_EXTRA
                                                             : sp_pkg::RX_STOP;
                        end
                        else
                            rxPhase <= rxPhase + 4'h1;
                    sp_pkg::RX_EXTRA:
                        if (rxPhase == PH_LAST)
                        begin
                            rxPhase <= 4'h0;
                            rxPar <= rxd;
                            rxState <= sp_pkg::RX_STOP;
                        end
                        else
                            rxPhase <= rxPhase + 4'h1;
                    sp_pkg::RX_STOP:
                        if (rxPhase == PH_LAST)
                        begin
                            // Only this stop bit is judged; idle hunts next start
                            rxState <= sp_pkg::RX_IDLE;
                            rxPhase <= 4'h0;
                            rxDone <= 1'b1;
                            rxWord <= sevenBit ? {1'b0, rxShift[7:1]} : rxShift;
                            rxStopBad <= !rxd;
                            // Seven-bit frames leave a stale bit at position 0
                            rxParBad <= usePar && ((^rxShift[7:1]) ^ (rxShift[0] & !sevenBit)
                                ^ rxPar) != mode.oddParity;
                            rxMpbIn <= useMp && rxPar;
                        end
                        else
                            rxPhase <= rxPhase + 4'h1;
                    default:
                        rxState <= sp_pkg::RX_IDLE;
                endcase
            end
        end
    end

    // -------------------------------------------------
    // Assertions
    // -------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_rxbuf_standby_zero: assert property (standby |=> rxBuf == 8'h00)
        else $error("receive buffer not cleared by standby");
    a_txbuf_standby_ones: assert property (standby |=> txBuf == 8'hff)
        else $error("transmit buffer not set by standby");
    a_mode_standby_zero: assert property (standby |=> mode == 8'h00)
        else $error("frame mode not cleared by standby");
    a_tx_load_gate: assert property ($rose(txBusy) |-> $past(txEn && !txEmpty))
        else $error("transmit started without a cleared empty flag");
    a_tx_load_flag: assert property ($rose(txBusy) |-> txEmpty)
        else $error("empty flag not set when shifter loaded");
    a_tx_start_low: assert property ($rose(txBusy) && !isSync |-> !txd)
        else $error("asynchronous frame lacks low start bit");
    a_tx_idle_high: assert property (!txBusy |-> txd)
        else $error("transmit line not idle high");
    a_sync_len_eight: assert property ($rose(txBusy) && isSync |-> txLeft == 4'h8)
        else $error("synchronous frame not eight bits");
    a_async_frame_len: assert property ($rose(txBusy) && !isSync |-> txLeft ==
        4'h2 + dataLen + {3'h0, usePar || useMp} + {3'h0, mode.stopTwo})
        else $error("asynchronous frame length wrong");
    a_tx_parity_sense: assert property ($rose(txBusy) && usePar && !sevenBit
        |-> (^txShift[9:1]) == mode.oddParity)
        else $error("transmitted parity sense wrong");
    a_tx_seven_drop: assert property ($rose(txBusy) && sevenBit && !usePar && !useMp
        |-> txShift[8])
        else $error("bit 7 sent in seven-bit character");
    a_rx_overrun_keep: assert property (rxDone && rxFull && !standby
        |=> rxBuf == $past(rxBuf) && overrun)
        else $error("unread receive data overwritten");

    c_async_frame: cover property ($rose(txBusy) && !isSync);
    c_sync_frame: cover property ($rose(txBusy) && isSync);
    c_rx_done: cover property (rxDone && !rxFull);
    c_rx_parity_err: cover property (rxDone && rxParBad);
endmodule

/* File: test/sp_remote_station.sv */
/*
 Remote serial station: captures frames seen on txd, sends frames on rxd.
 Assumes pins synchronous to ref_clk and a bit length in clocks set by the bench.
*/
`timescale 1ns/1ps
module sp_remote_station #(
    parameter int BITCLK = 4
) (
    input wire logic ref_clk,
    input wire logic txd,
    output logic rxd
);
    logic [11:0] got = 12'h000;
    int nBits = 9;
    int gotCount = 0;
    int bitClk = BITCLK;
    initial rxd = 1'b1;
    // ------------------------------------------
    // Capture, mid-bit sampling from first fall
    // ------------------------------------------
    always
    begin
        @(negedge txd);
        repeat (bitClk / 2) @(posedge ref_clk);
        got[0] = txd;
        for (int i = 1; i <= nBits; i++)
        begin
            repeat (bitClk) @(posedge ref_clk);
            got[i] = txd;
        end
        gotCount++;
    end
    // Caller builds the whole frame, so a bad parity is only sent on purpose
    task automatic send(input logic [11:0] bits, input int n);
        for (int i = 0; i < n; i++)
        begin
            rxd <= bits[i];
            repeat (bitClk) @(posedge ref_clk);
        end
        rxd <= 1'b1;
    endtask
endmodule

/* File: test/test_sp_serial_port.sv */
/*
 Self-checking bench of the serial port: registers, transmit and receive frames.
 Assumes the remote station model and an OVS of 4 with rate 0 (4 clocks a bit at prescale select 0, 16 at select 1).
*/
`timescale 1ns/1ps
`include "sp_consts.svh"
module test_sp_serial_port;
    logic ref_clk = 1'b0;
    logic resetn, standby, hsel, hwrite, hreadyout, hresp, rxd, txd, serClk, rresp;
    logic [31:0] haddr, hwdata, hrdata, rdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    sp_serial_port #(.OVS(4)) dut (.ref_clk(ref_clk), .resetn(resetn), .standby(standby),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rxd(rxd), .txd(txd), .serClk(serClk));
    sp_remote_station #(.BITCLK(4)) st (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
    initial forever #25 ref_clk = ~ref_clk;
    // ------------------------------------------
    // Shared tasks
    // ------------------------------------------
    task automatic stop_test();
        $display("errors %0d, checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_errors++;
            stop_test();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Ready and read data are taken at the rising edge that ends each phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rdata = hrdata;
        rresp = hresp;
    endtask
    // ------------------------------------------
    // Scenarios
    // ------------------------------------------
    task automatic test_regs();
        bus(0, `SP_OFS_MODE, 0);
        check("mode reset", rdata, 32'h00000000);
        bus(0, `SP_OFS_TXBUF, 0);
        check("txbuf reset", rdata, 32'h000000ff);
        bus(1, `SP_OFS_RXBUF, 32'h00000055);
        check("refused write response", {31'h0, rresp}, 32'h00000000);
        bus(0, `SP_OFS_RXBUF, 0);
        check("rxbuf read only", rdata, 32'h00000000);
        bus(1, `SP_OFS_TXBUF, 32'h0000005a);
        bus(0, `SP_OFS_TXBUF, 0);
        check("txbuf rw", rdata, 32'h0000005a);
        bus(1, `SP_OFS_MODE, 32'h0000003c);
        bus(0, `SP_OFS_MODE, 0);
        check("mode rw", rdata, 32'h0000003c);
        bus(0, 8'h18, 0);
        check("unmapped", rdata, 32'h00000000);
        standby <= 1'b1;
        @(posedge ref_clk);
        standby <= 1'b0;
        bus(0, `SP_OFS_TXBUF, 0);
        check("txbuf standby", rdata, 32'h000000ff);
        bus(0, `SP_OFS_MODE, 0);
        check("mode standby", rdata, 32'h00000000);
    endtask
    task automatic tx_case(input logic [7:0] m, input logic [7:0] d, input int n,
        input logic [11:0] exp);
        int cnt;
        int lowCnt;
        st.bitClk = 4 << (2 * m[1:0]);
        bus(1, `SP_OFS_MODE, {24'h000000, m});
        bus(1, `SP_OFS_CTRL, 32'h00000020);
        bus(1, `SP_OFS_TXBUF, {24'h000000, d});
        st.got = 12'h000;
        st.nBits = n;
        cnt = st.gotCount;
        check("line idle before clear", {31'h0, txd}, 32'h00000001);
        lowCnt = 0;
        bus(1, `SP_OFS_STAT, 0);
        for (int i = 0; i < 400 && st.gotCount == cnt; i++)
        begin
            @(posedge ref_clk);
            if (serClk === 1'b0)
                lowCnt++;
        end
        check("tx frame", {20'h00000, st.got}, {20'h00000, exp});
        // Synchronous: eight bits, each low for half of its 4 clocks
        check("serial clock lows", lowCnt, m[7] ? 16 : 0);
    endtask
    task automatic rx_case(input logic [7:0] m, input logic [11:0] bits, input int n,
        input logic [7:0] d, input logic [7:0] err);
        st.bitClk = 4 << (2 * m[1:0]);
        bus(1, `SP_OFS_MODE, {24'h000000, m});
        bus(1, `SP_OFS_CTRL, 32'h00000010);
        bus(1, `SP_OFS_STAT, 0);
        st.send(bits, n);
        for (int i = 0; i < 40; i++)
        begin
            bus(0, `SP_OFS_STAT, 0);
            if (rdata[6] === 1'b1)
                break;
        end
        bus(0, `SP_OFS_RXBUF, 0);
        check("rx data", rdata, {24'h000000, d});
        bus(0, `SP_OFS_STAT, 0);
        check("rx errors", rdata & 32'h00000038, {24'h000000, err});
    endtask
    initial
    begin
        resetn = 1'b0;
        standby = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h00000000;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        test_regs();
        tx_case(8'h00, 8'ha5, 9, 12'h34a);
        tx_case(8'h78, 8'hff, 10, 12'h6fe);
        tx_case(8'h20, 8'h07, 10, 12'h60e);
        tx_case(8'h30, 8'h07, 10, 12'h40e);
        tx_case(8'h24, 8'h07, 10, 12'h40e);
        tx_case(8'ha8, 8'h5a, 8, 12'h15a);
        tx_case(8'h01, 8'ha5, 9, 12'h34a);
        rx_case(8'h00, 12'h278, 10, 8'h3c, 8'h00);
        rx_case(8'h20, 12'h402, 11, 8'h01, 8'h08);
        rx_case(8'h30, 12'h402, 11, 8'h01, 8'h00);
        rx_case(8'h48, 12'h1aa, 9, 8'h55, 8'h00);
        rx_case(8'h60, 12'h302, 10, 8'h01, 8'h00);
        stop_test();
    end
endmodule
